// file: cnmt_defines.svh
// offsets, field positions, reset values and codes of the network-management state machine
`ifndef CNMT_DEFINES_SVH
`define CNMT_DEFINES_SVH
`define CNMT_ADDR_CTRL 4'h0
`define CNMT_ADDR_STATUS 4'h4
`define CNMT_ADDR_EMCY 4'h8
`define CNMT_CTRL_MASTER 0
`define CNMT_CTRL_RESTORE 1
`define CNMT_CTRL_RST_APP 2
`define CNMT_CTRL_RST_COMM 3
`define CNMT_MASTER_RST 1'b0
`define CNMT_CS_START 8'h01
`define CNMT_CS_STOP 8'h02
`define CNMT_CS_PREOP 8'h80
`define CNMT_CS_RST_NODE 8'h81
`define CNMT_CS_RST_COMM 8'h82
`define CNMT_EMCY_DV_LOST 16'hff10
`define CNMT_EMCY_CFG_FAIL 16'h6161
`endif

// file: cnmt_pkg.sv
// types of the network-management state machine
package cnmt_pkg;
	typedef enum logic [1:0] {
		CNMT_INIT = 2'b00,
		CNMT_PREOP = 2'b01,
		CNMT_OPER = 2'b10,
		CNMT_STOPPED = 2'b11
	} cnmt_state_t;
	typedef enum logic [1:0] {
		CNMT_PH_BASIC = 2'b00,
		CNMT_PH_RST_APP = 2'b01,
		CNMT_PH_RST_COMM = 2'b10,
		CNMT_PH_DONE = 2'b11
	} cnmt_phase_t;
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic clean;
	} cnmt_sync_st_t;
	typedef struct packed {
		cnmt_state_t state;
		cnmt_phase_t phase;
		logic master;
		logic restore_pend;
		logic param_rcv;
		logic data_upd;
		logic boot_done;
		logic dv_q;
		logic run_q;
		logic pend_dv_lost;
		logic pend_cfg_fail;
		logic emcy_valid;
		logic [15:0] emcy_code;
		logic [15:0] emcy_last;
		logic load_stored;
		logic load_default;
		logic hold_data;
		logic tx_retained;
		logic [31:0] rdata;
	} cnmt_st_t;
endpackage

// file: cnmt_sync_if.sv
// raw pin level and its filtered copy between the top and a synchroniser
`timescale 1ns/10ps
`default_nettype none
interface cnmt_sync_if;
	logic raw;
	logic clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface
`default_nettype wire

// file: cnmt_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module cnmt_sync
	import cnmt_pkg::*;
(
	input wire logic sys_clk, // device clock
	input wire logic rstn, // async reset, low
	cnmt_sync_if.sync sif // pin in, filtered level out
);
	cnmt_sync_st_t st_ff;
	cnmt_sync_st_t nxt_st;

	// first stage feeds only the second, never the compare
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = sif.raw;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		if (st_ff.s2 == st_ff.s3)
		begin
			nxt_st.clean = st_ff.s3;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign sif.clean = st_ff.clean;
endmodule
`default_nettype wire

// file: cnmt_top.sv
// network-management state machine of a fieldbus-to-CANopen bridge node
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cnmt_defines.svh"
module cnmt_top
	import cnmt_pkg::*;
(
	input wire logic sys_clk, // device clock, 250 MHz
	input wire logic rstn, // async reset, low
	input wire logic [3:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic plc_run_pin, // PLC switch, high = RUN
	input wire logic plc_dv_pin, // data valid from PLC side
	input wire logic fb_link_pin, // fieldbus connection up
	input wire logic nmt_valid, // network command strobe
	input wire logic [7:0] nmt_cmd, // network command specifier
	input wire logic stored_valid, // stored parameters present
	input wire logic param_telegram, // parameter telegram received
	input wire logic data_updated, // all PLC data updated once
	input wire logic mand_nodes_ok, // mandatory nodes up, configured
	input wire logic guard_ok, // heartbeat or guarding running
	input wire logic cfg_fail, // concise configuration failed
	output logic [1:0] nmt_state, // current network state
	output logic [1:0] init_phase, // initialization phase
	output logic sdo_en, // configuration access allowed
	output logic pdo_en, // process data exchange active
	output logic guard_en, // guarding and heartbeat allowed
	output logic load_stored, // load stored parameters, pulse
	output logic load_default, // load profile defaults, pulse
	output logic hold_data, // keep last received data
	output logic tx_retained, // send retained data, pulse
	output logic diag_param_err, // parameterization error
	output logic diag_error, // general error until boot-up
	output logic emcy_valid, // emergency pending
	output logic [15:0] emcy_code, // emergency code
	input wire logic emcy_ready // emergency taken
);
	cnmt_st_t st_ff;
	cnmt_st_t nxt_st;
	cnmt_sync_if run_if();
	cnmt_sync_if dv_if();
	cnmt_sync_if link_if();
	logic run;
	logic dv;
	logic link;
	logic cmd_start;
	logic cmd_stop;
	logic cmd_preop;
	logic cmd_rst_node;
	logic cmd_rst_comm;
	logic loc_rst_app;
	logic loc_rst_comm;
	logic ctrl_wr;
	logic emcy_take;
	logic dv_lost;
	logic run_rise;
	logic boot_cond;

	assign run_if.raw = plc_run_pin;
	assign dv_if.raw = plc_dv_pin;
	assign link_if.raw = fb_link_pin;

	cnmt_sync u_run_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.sif(run_if)
	);

	cnmt_sync u_dv_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.sif(dv_if)
	);

	cnmt_sync u_link_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.sif(link_if)
	);

	assign run = run_if.clean;
	assign dv = dv_if.clean;
	assign link = link_if.clean;

	// start, stop and pre-operational commands are only decoded in slave mode, reset commands in both modes
	// other specifiers match no decode
	assign cmd_start = nmt_valid && !st_ff.master && (nmt_cmd == `CNMT_CS_START);
	assign cmd_stop = nmt_valid && !st_ff.master && (nmt_cmd == `CNMT_CS_STOP);
	assign cmd_preop = nmt_valid && !st_ff.master && (nmt_cmd == `CNMT_CS_PREOP);
	assign cmd_rst_node = nmt_valid && (nmt_cmd == `CNMT_CS_RST_NODE);
	assign cmd_rst_comm = nmt_valid && (nmt_cmd == `CNMT_CS_RST_COMM);

	assign ctrl_wr = reg_wr && (reg_addr == `CNMT_ADDR_CTRL);
	assign loc_rst_app = ctrl_wr && reg_wdata[`CNMT_CTRL_RST_APP];
	assign loc_rst_comm = ctrl_wr && reg_wdata[`CNMT_CTRL_RST_COMM];

	assign emcy_take = st_ff.emcy_valid && emcy_ready;
	assign dv_lost = st_ff.dv_q && !dv;
	assign run_rise = run && !st_ff.run_q;
	assign boot_cond = mand_nodes_ok && guard_ok && st_ff.data_upd;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.dv_q = dv;
		nxt_st.run_q = run;
		nxt_st.load_stored = 1'b0;
		nxt_st.load_default = 1'b0;
		nxt_st.tx_retained = 1'b0;
		nxt_st.rdata = 32'h0;

		if (ctrl_wr)
		begin
			nxt_st.master = reg_wdata[`CNMT_CTRL_MASTER];
		end
		// restore request kept until next load
		if (ctrl_wr && reg_wdata[`CNMT_CTRL_RESTORE])
		begin
			nxt_st.restore_pend = 1'b1;
		end
		if (param_telegram)
		begin
			nxt_st.param_rcv = 1'b1;
		end
		if (data_updated)
		begin
			nxt_st.data_upd = 1'b1;
		end

		// retain data while PLC stopped or link lost
		nxt_st.hold_data = !run || !link;
		// replay retained data on return to RUN
		if (run_rise && link && (st_ff.state == CNMT_OPER))
		begin
			nxt_st.tx_retained = 1'b1;
		end

		// state moves only on listed causes
		case (st_ff.state)
			CNMT_INIT:
			begin
				case (st_ff.phase)
					CNMT_PH_BASIC:
					begin
						nxt_st.phase = CNMT_PH_RST_APP;
						nxt_st.data_upd = data_updated;
						nxt_st.boot_done = 1'b0;
					end
					CNMT_PH_RST_APP:
					begin
						// stored values unless absent or restore asked
						if (stored_valid && !st_ff.restore_pend)
						begin
							nxt_st.load_stored = 1'b1;
						end
						else
						begin
							nxt_st.load_default = 1'b1;
						end
						nxt_st.restore_pend = ctrl_wr && reg_wdata[`CNMT_CTRL_RESTORE];
						nxt_st.phase = CNMT_PH_RST_COMM;
					end
					CNMT_PH_RST_COMM:
					begin
						nxt_st.phase = CNMT_PH_DONE;
					end
					default:
					begin
						nxt_st.state = CNMT_PREOP;
						if (!st_ff.master)
						begin
							nxt_st.boot_done = 1'b1;
						end
					end
				endcase
			end
			CNMT_PREOP:
			begin
				if (st_ff.master)
				begin
					// RUN enters operational only after data update
					if (run && link && st_ff.data_upd)
					begin
						nxt_st.state = CNMT_OPER;
						nxt_st.tx_retained = 1'b1;
					end
				end
				else if (cmd_start)
				begin
					nxt_st.state = CNMT_OPER;
				end
				else if (cmd_stop)
				begin
					nxt_st.state = CNMT_STOPPED;
				end
			end
			CNMT_OPER:
			begin
				if (st_ff.master)
				begin
					if (!run)
					begin
						nxt_st.state = CNMT_PREOP;
					end
				end
				else if (dv_lost)
				begin
					nxt_st.state = CNMT_PREOP;
				end
				else if (cmd_preop)
				begin
					nxt_st.state = CNMT_PREOP;
				end
				else if (cmd_stop)
				begin
					nxt_st.state = CNMT_STOPPED;
				end
			end
			CNMT_STOPPED:
			begin
				// a switch to master leaves stopped at once
				if (st_ff.master)
				begin
					nxt_st.state = CNMT_PREOP;
				end
				else if (cmd_start)
				begin
					nxt_st.state = CNMT_OPER;
				end
				else if (cmd_preop)
				begin
					nxt_st.state = CNMT_PREOP;
				end
			end
			default:
			begin
				nxt_st.state = CNMT_INIT;
				nxt_st.phase = CNMT_PH_BASIC;
			end
		endcase

		// resets re-enter initialization from running states
		if (st_ff.state != CNMT_INIT)
		begin
			if (cmd_rst_node || loc_rst_app)
			begin
				nxt_st.state = CNMT_INIT;
				nxt_st.phase = CNMT_PH_BASIC;
			end
			else if (cmd_rst_comm || loc_rst_comm)
			begin
				nxt_st.state = CNMT_INIT;
				nxt_st.phase = CNMT_PH_RST_COMM;
				nxt_st.boot_done = 1'b0;
			end
		end

		// master boot-up completes on all criteria
		if (st_ff.master && (nxt_st.state != CNMT_INIT) && boot_cond)
		begin
			nxt_st.boot_done = 1'b1;
		end

		// set wins over the clear by the taken emergency
		if (emcy_take)
		begin
			nxt_st.emcy_valid = 1'b0;
		end
		if (!st_ff.emcy_valid || emcy_take)
		begin
			if (st_ff.pend_dv_lost)
			begin
				nxt_st.emcy_valid = 1'b1;
				nxt_st.emcy_code = `CNMT_EMCY_DV_LOST;
				nxt_st.pend_dv_lost = 1'b0;
			end
			else if (st_ff.pend_cfg_fail)
			begin
				nxt_st.emcy_valid = 1'b1;
				nxt_st.emcy_code = `CNMT_EMCY_CFG_FAIL;
				nxt_st.pend_cfg_fail = 1'b0;
			end
		end
		if (emcy_take)
		begin
			nxt_st.emcy_last = st_ff.emcy_code;
		end
		// emergency on data-valid loss in slave operation
		if (dv_lost && !st_ff.master && (st_ff.state == CNMT_OPER))
		begin
			nxt_st.pend_dv_lost = 1'b1;
		end
		if (cfg_fail)
		begin
			nxt_st.pend_cfg_fail = 1'b1;
		end

		if (reg_rd)
		begin
			case (reg_addr)
				`CNMT_ADDR_CTRL:
				begin
					nxt_st.rdata = {28'h0, 2'h0, st_ff.restore_pend, st_ff.master};
				end
				`CNMT_ADDR_STATUS:
				begin
					nxt_st.rdata = {20'h0, link, dv, run, st_ff.boot_done,
						st_ff.param_rcv, st_ff.data_upd, st_ff.phase, st_ff.state, 2'h0};
				end
				`CNMT_ADDR_EMCY:
				begin
					nxt_st.rdata = {st_ff.emcy_last, st_ff.emcy_code};
				end
				default:
				begin
					nxt_st.rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_ff <= '{state: CNMT_INIT, phase: CNMT_PH_BASIC, master: `CNMT_MASTER_RST,
				hold_data: 1'b1, default: '0};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign nmt_state = st_ff.state;
	assign init_phase = st_ff.phase;
	// configuration access outside init and stopped
	assign sdo_en = (st_ff.state == CNMT_PREOP) || (st_ff.state == CNMT_OPER);
	assign pdo_en = (st_ff.state == CNMT_OPER);
	assign guard_en = (st_ff.state != CNMT_INIT);
	assign load_stored = st_ff.load_stored;
	assign load_default = st_ff.load_default;
	assign hold_data = st_ff.hold_data;
	assign tx_retained = st_ff.tx_retained;
	// parameter error, then general error until boot-up
	assign diag_param_err = !st_ff.param_rcv;
	assign diag_error = st_ff.param_rcv && !st_ff.boot_done;
	assign emcy_valid = st_ff.emcy_valid;
	assign emcy_code = st_ff.emcy_code;
	assign reg_rdata = st_ff.rdata;
endmodule
`default_nettype wire

// file: cnmt_props.sv
// assertions on the ports of the network state machine
`timescale 1ns/10ps
`default_nettype none
module cnmt_props
	import cnmt_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic rstn, // reset, low
	input wire logic [3:0] reg_addr, // address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic nmt_valid, // command strobe
	input wire logic [7:0] nmt_cmd, // command
	input wire logic [1:0] nmt_state, // state
	input wire logic [1:0] init_phase, // phase
	input wire logic sdo_en, // config access
	input wire logic pdo_en, // data exchange
	input wire logic guard_en, // guarding
	input wire logic load_stored, // load pulse
	input wire logic diag_param_err, // param diag
	input wire logic diag_error, // general diag
	input wire logic emcy_valid, // emergency
	input wire logic [15:0] emcy_code, // code
	input wire logic emcy_ready // taken
);
	// master flag is only visible through the control write
	logic mst_ff;
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			mst_ff <= 1'b0;
		else if (reg_wr && reg_addr == 4'h0)
			mst_ff <= reg_wdata[0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	property p_init;
		nmt_state == 2'h0 && init_phase == 2'h0 |=> init_phase == 2'h1 ##1 init_phase == 2'h2
			##1 init_phase == 2'h3 ##1 nmt_state == 2'h1;
	endproperty
	a_init: assert property (p_init) else $error("init phases out of order");
	property p_oper;
		pdo_en == (nmt_state == 2'h2) && sdo_en == (nmt_state == 2'h1 || nmt_state == 2'h2);
	endproperty
	a_oper: assert property (p_oper) else $error("access enables wrong for state");
	property p_stop;
		nmt_state == 2'h3 |-> guard_en && !pdo_en && !sdo_en;
	endproperty
	a_stop: assert property (p_stop) else $error("stopped state not quiet");
	property p_start;
		nmt_valid && nmt_cmd == 8'h01 && nmt_state == 2'h1 && !mst_ff |=> nmt_state == 2'h2;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_rst;
		nmt_valid && (nmt_cmd == 8'h81 || nmt_cmd == 8'h82) && nmt_state != 2'h0 |=>
			nmt_state == 2'h0 && init_phase == ($past(nmt_cmd) == 8'h81 ? 2'h0 : 2'h2);
	endproperty
	a_rst: assert property (p_rst) else $error("reset command not taken");
	property p_nostop;
		mst_ff && nmt_state != 2'h3 |=> nmt_state != 2'h3;
	endproperty
	a_nostop: assert property (p_nostop) else $error("master entered stopped");
	property p_emcy;
		emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_code);
	endproperty
	a_emcy: assert property (p_emcy) else $error("emergency dropped before taken");
	property p_diag;
		diag_param_err |-> !diag_error;
	endproperty
	a_diag: assert property (p_diag) else $error("both diagnostics raised");
	property p_ign;
		nmt_valid && nmt_cmd[6] && !reg_wr && !mst_ff && (nmt_state == 2'h1 || nmt_state == 2'h3)
			|=> $stable(nmt_state);
	endproperty
	a_ign: assert property (p_ign) else $error("unknown command moved state");
	property p_load;
		load_stored |-> nmt_state == 2'h0;
	endproperty
	a_load: assert property (p_load) else $error("parameter load outside init");
endmodule
`default_nettype wire

// file: cnmt_net_model.sv
// remote network master: sends commands and takes emergencies
`timescale 1ns/10ps
`default_nettype none
module cnmt_net_model
(
	input wire logic sys_clk, // clock
	input wire logic slow, // late take of emergencies
	input wire logic emcy_valid, // emergency offered
	input wire logic [15:0] emcy_code, // code offered
	output logic emcy_ready = 1'b0, // emergency taken
	output logic nmt_valid = 1'b0, // command strobe
	output logic [7:0] nmt_cmd = 8'h5a // command
);
	int wait_n = 0;
	logic [15:0] got_q[$];
	always @(posedge sys_clk)
	begin
		if (emcy_ready && emcy_valid)
			got_q.push_back(emcy_code);
		emcy_ready <= emcy_valid && !emcy_ready && wait_n >= (slow ? 4 : 0);
		wait_n <= (emcy_valid && !emcy_ready) ? wait_n + 1 : 0;
	end
	task automatic send(input logic [7:0] c);
		@(posedge sys_clk);
		nmt_valid <= 1'b1;
		nmt_cmd <= c;
		@(posedge sys_clk);
		nmt_valid <= 1'b0;
		// released lines carry no stale command
		nmt_cmd <= ~c;
	endtask
endmodule
`default_nettype wire

// file: test_canopen_nmt_state_machine.sv
// self-checking bench of the network state machine
`timescale 1ns/10ps
`default_nettype none
module test_canopen_nmt_state_machine;
	import cnmt_pkg::*;
	logic sys_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0, dv = 1'b1, link = 1'b1;
	logic stv = 1'b1, ptel = 1'b0, dupd = 1'b0, gok = 1'b1, cfg = 1'b0, slow = 1'b0, mst = 1'b0, mok = 1'b1;
	logic [3:0] ra = 4'h0;
	logic [31:0] wd = 32'h0, rdat;
	logic nv, er, pdo, ls, ld, hold, dpe, derr, ev, tx;
	logic [7:0] nc;
	logic [1:0] st, ph;
	logic [15:0] ec;
	logic [7:0] tbl [6] = '{8'h01, 8'h02, 8'h01, 8'h80, 8'h02, 8'h80};
	int err_total = 0, compares = 0, n_ls = 0, n_ld = 0, n_tx = 0, exp_st = 0, seed = 32'hf828b694;
	always #2 sys_clk = ~sys_clk;
	cnmt_top DUT (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdat), .plc_run_pin(run), .plc_dv_pin(dv), .fb_link_pin(link), .nmt_valid(nv), .nmt_cmd(nc),
		.stored_valid(stv), .param_telegram(ptel), .data_updated(dupd), .mand_nodes_ok(mok), .guard_ok(gok),
		.cfg_fail(cfg), .nmt_state(st), .init_phase(ph), .sdo_en(), .pdo_en(pdo), .guard_en(), .load_stored(ls),
		.load_default(ld), .hold_data(hold), .tx_retained(tx), .diag_param_err(dpe), .diag_error(derr),
		.emcy_valid(ev), .emcy_code(ec), .emcy_ready(er));
	cnmt_net_model NET (.sys_clk(sys_clk), .slow(slow), .emcy_valid(ev), .emcy_code(ec), .emcy_ready(er),
		.nmt_valid(nv), .nmt_cmd(nc));
	always @(posedge sys_clk)
	begin
		n_ls += ls;
		n_ld += ld;
		n_tx += tx;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		ra <= a;
		wd <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
		wd <= ~d;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		rd <= 1'b1;
		ra <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(posedge sys_clk);
		chk(rdat, exp);
	endtask
	// next state of the behavioural model
	function automatic int nxt(input int s, input int c);
		if (s == 0)
			return 0;
		if (c == 8'h81 || c == 8'h82)
			return 0;
		if (mst)
			return s;
		if (c == 8'h01)
			return 2;
		if (c == 8'h02)
			return 3;
		return (c == 8'h80) ? 1 : s;
	endfunction
	task automatic cmd(input logic [7:0] c);
		exp_st = nxt(exp_st, c);
		NET.send(c);
		#1;
		chk(st, exp_st);
	endtask
	task automatic wait_st(input int s);
		for (int k = 0; k < 60 && st !== s[1:0]; k++)
			@(posedge sys_clk);
		exp_st = s;
		chk(st, s);
	endtask
	task automatic get_emcy(input logic [15:0] c);
		for (int k = 0; k < 60 && NET.got_q.size() == 0; k++)
			@(posedge sys_clk);
		chk(NET.got_q.size(), 1);
		if (NET.got_q.size() > 0)
			chk(NET.got_q.pop_front(), c);
	endtask
	task give_verdict;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#(4 * 20000);
		err_total++;
		give_verdict();
	end
	initial
	begin
		repeat (5) @(posedge sys_clk);
		chk({st, ph, dpe, hold}, 6'h03);
		@(posedge sys_clk);
		rstn <= 1'b1;
		wait_st(1);
		chk({ph, 6'(n_ls), 6'(n_ld)}, 14'h3040);
		rreg(4'h4, 32'h0000_0d34);
		rreg(4'hc, 32'h0);
		wreg(4'h0, 32'h6);
		wait_st(0);
		wait_st(1);
		chk(n_ld, 1);
		$display("test init done");
		ptel <= 1'b1;
		@(posedge sys_clk);
		ptel <= 1'b0;
		cmd(8'h81);
		repeat (2) @(posedge sys_clk);
		chk({dpe, derr}, 2'b01);
		wait_st(1);
		chk({dpe, derr}, 2'b00);
		foreach (tbl[i])
			cmd(tbl[i]);
		for (int i = 0; i < 4; i++)
			cmd({2'b01, 6'($random(seed))});
		cmd(8'h01);
		cmd(8'h82);
		chk(ph, 2);
		wait_st(1);
		$display("test commands done");
		slow <= 1'b1;
		cmd(8'h01);
		dv <= 1'b0;
		wait_st(1);
		get_emcy(16'hff10);
		slow <= 1'b0;
		cfg <= 1'b1;
		@(posedge sys_clk);
		cfg <= 1'b0;
		get_emcy(16'h6161);
		rreg(4'h8, 32'h6161_6161);
		$display("test emergency done");
		wreg(4'h0, 32'h1);
		mst = 1'b1;
		cmd(8'h01);
		cmd(8'h02);
		run <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk(st, 1);
		dupd <= 1'b1;
		@(posedge sys_clk);
		dupd <= 1'b0;
		wait_st(2);
		chk(hold, 0);
		link <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk(hold, 1);
		link <= 1'b1;
		run <= 1'b0;
		wait_st(1);
		chk(hold, 1);
		run <= 1'b1;
		wait_st(2);
		@(posedge sys_clk);
		chk(n_tx, 2);
		gok <= 1'b0;
		wreg(4'h0, 32'h9);
		wait_st(0);
		wait_st(1);
		repeat (4) @(posedge sys_clk);
		chk(derr, 1);
		gok <= 1'b1;
		mok <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk(derr, 1);
		mok <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(derr, 0);
		$display("test master done");
		give_verdict();
	end
endmodule
bind cnmt_top cnmt_props u_props (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .nmt_valid(nmt_valid), .nmt_cmd(nmt_cmd), .nmt_state(nmt_state), .init_phase(init_phase),
	.sdo_en(sdo_en), .pdo_en(pdo_en), .guard_en(guard_en), .load_stored(load_stored),
	.diag_param_err(diag_param_err), .diag_error(diag_error), .emcy_valid(emcy_valid), .emcy_code(emcy_code),
	.emcy_ready(emcy_ready));
`default_nettype wire
